// >>> link_pacing_consts.vh
// constants for the link pacing and fairness controller
`ifndef LINK_PACING_CONSTS_VH
`define LINK_PACING_CONSTS_VH

// ********************************************************************
// register byte offsets
// ********************************************************************
`define REG_CTRL_ADDR 8'h00
`define REG_QUOTA_ADDR 8'h04
`define REG_BUFCFG_ADDR 8'h08
`define REG_PACE_STAT_ADDR 8'h0C
`define REG_FRAME_CNT_ADDR 8'h10
`define REG_FAIR_STAT_ADDR 8'h14

// ********************************************************************
// control register fields
// ********************************************************************
`define CTRL_EXT_EN_BIT 0
`define CTRL_BOUNCE_BIT 1
`define CTRL_EXT_CAP_BIT 2

// ********************************************************************
// port link states
// ********************************************************************
`define PST_OTHER 2'h0
`define PST_ENABLED 2'h1
`define PST_CHECK 2'h2
`define PST_READY 2'h3

// ********************************************************************
// counter values and widths
// ********************************************************************
`define OUT_FULL 8'hFF
`define OUT_ZERO 8'h00
`define OUT_ONE 8'h01
`define CRED_ONE 9'h001
`define CRED_ZERO 9'h000
`define FCNT_ZERO 16'h0000
`define FCNT_MAX 16'hFFFF
`define XFER_ZERO 8'h00
`define XFER_MAX 8'hFF
`define WORD_ZERO 32'h00000000

`endif

// >>> link_pacing_fairness_ctrl.v
// per-port receiver-ready pacing and fairness token controller
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "link_pacing_consts.vh"

module link_pacing_fairness_ctrl (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // port state and receive character stream
    input wire [1:0] port_state,
    input wire rx_char_valid,
    input wire rx_char_is_rr,
    input wire rx_ctrl_field_paced,
    // receive buffer status
    input wire rx_buf_free,
    input wire rx_buf_added,
    input wire rx_buf_removed,
    // transmit character stream
    input wire tx_char_sent,
    input wire tx_char_is_rr,
    input wire tx_ctrl_field_paced,
    input wire tx_rr_pair_done,
    // pacing outputs
    output reg tx_frame_permit,
    output reg tx_control_permit,
    output reg rr_send_req,
    // transfer bookkeeping
    input wire xfer_open,
    input wire xfer_close,
    // fairness, index 0 clockwise, 1 counter-clockwise
    input wire [1:0] token_rx,
    input wire [1:0] return_token_rx,
    input wire [1:0] app_frame_done,
    input wire [1:0] frames_waiting,
    input wire [1:0] cut_through_pending,
    output reg [1:0] token_fwd,
    output reg [1:0] token_refl,
    output reg [1:0] return_fwd,
    output reg [1:0] return_refl,
    output reg [1:0] originate_permit
);

    // ****************************************************************
    // byte-lane merge for register writes
    // ****************************************************************
    function [31:0] lane_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        integer i;
        begin
            lane_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // ****************************************************************
    // software registers
    // ****************************************************************
    reg [31:0] ctrl_reg; // ext enable, bounce, ext capable
    reg [31:0] quota_reg; // a quota low byte, b quota next
    reg [31:0] bufcfg_reg; // total rx buffers, extra buffers
    wire ext_en = ctrl_reg[`CTRL_EXT_EN_BIT];
    wire bounce_mode = ctrl_reg[`CTRL_BOUNCE_BIT];
    wire ext_cap = ctrl_reg[`CTRL_EXT_CAP_BIT];
    wire [7:0] a_quota = quota_reg[7:0];
    wire [7:0] b_quota = quota_reg[15:8];
    wire [7:0] rx_buf_total = bufcfg_reg[7:0];
    wire [7:0] rx_buf_extra = bufcfg_reg[15:8];

    // ****************************************************************
    // state
    // ****************************************************************
    reg [7:0] outstanding_pacing_count_reg; // frames sent awaiting pair
    reg [8:0] pacing_credit_count_reg; // signed credit, bit 8 sign
    reg [1:0] port_state_prev_reg; // for enabled entry detect
    reg ext_en_prev_reg; // for option toggle detect
    reg rr_half_reg; // first ready char of a pair seen
    reg last_tx_rr_reg; // last transmitted char was ready
    reg [7:0] xfer_count_reg; // open outbound transfers
    reg [15:0] frame_cnt_reg [0:1]; // originated frames per direction
    reg [1:0] holding_reg; // primary token held per direction

    // ****************************************************************
    // derived combinational terms
    // ****************************************************************
    wire in_ready = (port_state == `PST_READY);
    wire enter_enabled = (port_state == `PST_ENABLED) &&
        (port_state_prev_reg != `PST_ENABLED);
    wire rx_rr_pair = rx_char_valid && rx_char_is_rr && rr_half_reg;
    wire credit_pos = !pacing_credit_count_reg[8] &&
        (pacing_credit_count_reg != `CRED_ZERO);
    wire [15:0] hold_limit = a_quota * xfer_count_reg;
    wire [15:0] idle_limit = b_quota * xfer_count_reg;
    wire opt_on = ext_cap && ext_en && !ext_en_prev_reg;
    wire opt_off = ext_cap && !ext_en && ext_en_prev_reg;

    // ****************************************************************
    // wishbone slave: one wait state, write lands on the ack edge
    // ****************************************************************
    wire wb_req = wb_cyc_i && wb_stb_i;
    wire wb_wr = wb_req && wb_we_i && wb_ack_o;

    // ack and read data
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `WORD_ZERO;
        end else begin
            // ack drops the cycle after it was given
            wb_ack_o <= wb_req && !wb_ack_o;
            if (wb_req && !wb_ack_o) begin
                if (wb_adr_i == `REG_CTRL_ADDR) begin
                    wb_dat_o <= ctrl_reg;
                end else if (wb_adr_i == `REG_QUOTA_ADDR) begin
                    wb_dat_o <= quota_reg;
                end else if (wb_adr_i == `REG_BUFCFG_ADDR) begin
                    wb_dat_o <= bufcfg_reg;
                end else if (wb_adr_i == `REG_PACE_STAT_ADDR) begin
                    wb_dat_o <= {7'h00, last_tx_rr_reg, rr_half_reg,
                        6'h00, pacing_credit_count_reg,
                        outstanding_pacing_count_reg[7:0]};
                end else if (wb_adr_i == `REG_FRAME_CNT_ADDR) begin
                    wb_dat_o <= {frame_cnt_reg[1], frame_cnt_reg[0]};
                end else if (wb_adr_i == `REG_FAIR_STAT_ADDR) begin
                    wb_dat_o <= {20'h00000, holding_reg, 2'h0, xfer_count_reg};
                end else begin
                    // unmapped reads as zero, still acked
                    wb_dat_o <= `WORD_ZERO;
                end
            end
        end
    end

    // writable registers
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= `WORD_ZERO;
            quota_reg <= `WORD_ZERO;
            bufcfg_reg <= `WORD_ZERO;
        end else if (wb_wr) begin
            if (wb_adr_i == `REG_CTRL_ADDR) begin
                ctrl_reg <= lane_merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h00000007;
            end else if (wb_adr_i == `REG_QUOTA_ADDR) begin
                quota_reg <= lane_merge(quota_reg, wb_dat_i, wb_sel_i) & 32'h0000FFFF;
            end else if (wb_adr_i == `REG_BUFCFG_ADDR) begin
                bufcfg_reg <= lane_merge(bufcfg_reg, wb_dat_i, wb_sel_i) & 32'h0000FFFF;
            end
        end
    end

    // ****************************************************************
    // character tracking
    // ****************************************************************
    // history of both streams
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            port_state_prev_reg <= `PST_OTHER;
            ext_en_prev_reg <= 1'b0;
            rr_half_reg <= 1'b0;
            last_tx_rr_reg <= 1'b0;
        end else begin
            port_state_prev_reg <= port_state;
            ext_en_prev_reg <= ext_en;
            if (rx_char_valid) begin
                rr_half_reg <= rx_char_is_rr && !rr_half_reg;
            end
            if (tx_char_sent) begin
                last_tx_rr_reg <= tx_char_is_rr;
            end
        end
    end

    // ****************************************************************
    // outstanding pacing counter
    // ****************************************************************
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            outstanding_pacing_count_reg <= `OUT_ZERO;
        end else if (enter_enabled) begin
            outstanding_pacing_count_reg <= ext_cap ? `OUT_FULL : `OUT_ONE;
        end else if (!ext_cap) begin
            // set on send, clear on pair
            if (tx_ctrl_field_paced) begin
                outstanding_pacing_count_reg <= `OUT_ONE;
            end else if (rx_rr_pair) begin
                outstanding_pacing_count_reg <= `OUT_ZERO;
            end
        end else begin
            // up on send, down on pair
            if (tx_ctrl_field_paced && !rx_rr_pair) begin
                outstanding_pacing_count_reg <= outstanding_pacing_count_reg + `OUT_ONE;
            end else if (rx_rr_pair && !tx_ctrl_field_paced) begin
                outstanding_pacing_count_reg <= outstanding_pacing_count_reg - `OUT_ONE;
            end
        end
    end
    // received pairs stop here, never relayed

    // ****************************************************************
    // pacing credit counter
    // ****************************************************************
    reg [8:0] credit_next;
    reg [8:0] credit_up;
    reg [8:0] credit_down;
    always @* begin
        credit_up = `CRED_ZERO;
        credit_down = `CRED_ZERO;
        if (ext_cap && ext_en) begin
            credit_up = rx_buf_added ? `CRED_ONE : `CRED_ZERO;
            credit_down = (tx_rr_pair_done ? `CRED_ONE : `CRED_ZERO) +
                (rx_buf_removed ? `CRED_ONE : `CRED_ZERO);
        end else begin
            credit_up = rx_ctrl_field_paced ? `CRED_ONE : `CRED_ZERO;
            credit_down = tx_rr_pair_done ? `CRED_ONE : `CRED_ZERO;
        end
        if (opt_on) begin
            credit_up = credit_up + {1'b0, rx_buf_extra};
        end
        // extras leave service, may go negative
        if (opt_off) begin
            credit_down = credit_down + {1'b0, rx_buf_extra};
        end
        credit_next = pacing_credit_count_reg + credit_up - credit_down;
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pacing_credit_count_reg <= `CRED_ZERO;
        end else if (enter_enabled) begin
            if (ext_cap && ext_en) begin
                pacing_credit_count_reg <= {1'b0, rx_buf_total};
            end else begin
                pacing_credit_count_reg <= `CRED_ONE;
            end
        end else if (!ext_cap) begin
            if (rx_ctrl_field_paced) begin
                pacing_credit_count_reg <= `CRED_ONE;
            end else if (tx_rr_pair_done) begin
                pacing_credit_count_reg <= `CRED_ZERO;
            end
        end else begin
            pacing_credit_count_reg <= credit_next;
        end
    end

    // ****************************************************************
    // transmit permissions and ready pair request
    // ****************************************************************
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_frame_permit <= 1'b0;
            tx_control_permit <= 1'b0;
            rr_send_req <= 1'b0;
        end else begin
            tx_frame_permit <= in_ready && (ext_cap ?
                (outstanding_pacing_count_reg != `OUT_FULL) :
                (outstanding_pacing_count_reg == `OUT_ZERO));
            tx_control_permit <= (port_state == `PST_ENABLED) ||
                (port_state == `PST_CHECK) || in_ready;
            // credit, buffer, no ready char last
            rr_send_req <= in_ready && credit_pos && rx_buf_free &&
                !last_tx_rr_reg && !tx_rr_pair_done &&
                !(tx_char_sent && tx_char_is_rr);
        end
    end

    // ****************************************************************
    // outstanding transfer count
    // ****************************************************************
    // open transfer tracking
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            xfer_count_reg <= `XFER_ZERO;
        end else if (xfer_open && !xfer_close && xfer_count_reg != `XFER_MAX) begin
            xfer_count_reg <= xfer_count_reg + 8'h01;
        end else if (xfer_close && !xfer_open && xfer_count_reg != `XFER_ZERO) begin
            xfer_count_reg <= xfer_count_reg - 8'h01;
        end
    end

    // ****************************************************************
    // fairness engine, one copy per direction
    // ****************************************************************
    // separate direction state
    genvar d;
    generate
        for (d = 0; d < 2; d = d + 1) begin : dir_g
            wire quota_met = (frame_cnt_reg[d] >= hold_limit) ||
                (holding_reg[d] && !frames_waiting[d]);
            // token leaves this cycle, either just arrived or held
            wire pass_now = quota_met && (holding_reg[d] || token_rx[d]);

            // token holding and originated frame count
            always @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    holding_reg[d] <= 1'b0;
                    frame_cnt_reg[d] <= `FCNT_ZERO;
                end else if (pass_now) begin
                    holding_reg[d] <= 1'b0;
                    frame_cnt_reg[d] <= `FCNT_ZERO;
                end else begin
                    // second token while holding is dropped
                    if (token_rx[d]) begin
                        holding_reg[d] <= 1'b1;
                    end
                    if (app_frame_done[d] && frame_cnt_reg[d] != `FCNT_MAX) begin
                        frame_cnt_reg[d] <= frame_cnt_reg[d] + 16'h0001;
                    end
                end
            end

            // token emission and origination permit
            always @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    token_fwd[d] <= 1'b0;
                    token_refl[d] <= 1'b0;
                    return_fwd[d] <= 1'b0;
                    return_refl[d] <= 1'b0;
                    originate_permit[d] <= 1'b0;
                end else begin
                    token_fwd[d] <= pass_now && !bounce_mode;
                    token_refl[d] <= pass_now && bounce_mode;
                    return_fwd[d] <= return_token_rx[d] && !bounce_mode;
                    return_refl[d] <= return_token_rx[d] && bounce_mode;
                    // holding and unmet, or idle link under idle limit
                    originate_permit[d] <= (holding_reg[d] && !quota_met) ||
                        (!cut_through_pending[d] && (idle_limit > frame_cnt_reg[d]));
                end
            end
        end
    endgenerate

endmodule // link_pacing_fairness_ctrl
`default_nettype wire

// >>> link_pacing_fairness_ctrl_asserts.sv
// checker for the pacing and fairness controller
`timescale 1ns/100ps
`default_nettype none
module link_pacing_fairness_ctrl_asserts (
    // clock, reset, bus
    input wire mclk,
    input wire resetn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // pacing
    input wire [1:0] port_state,
    input wire rx_buf_free,
    input wire tx_frame_permit,
    input wire tx_control_permit,
    input wire rr_send_req,
    // fairness
    input wire [1:0] return_token_rx,
    input wire [1:0] token_fwd,
    input wire [1:0] token_refl,
    input wire [1:0] return_fwd,
    input wire [1:0] return_refl
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request"); // bus
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle"); // bus
    property p_ctrl_on;
        (port_state != 2'h0) [*3] |-> tx_control_permit;
    endproperty
    a_ctrl_on: assert property (p_ctrl_on) else $error("control frame blocked");
    property p_ctrl_off;
        (port_state == 2'h0) [*3] |-> !tx_control_permit;
    endproperty
    a_ctrl_off: assert property (p_ctrl_off) else $error("control permit when idle");
    property p_frame_ready;
        (port_state != 2'h3) [*3] |-> !tx_frame_permit;
    endproperty
    a_frame_ready: assert property (p_frame_ready) else $error("frame permit outside ready");
    property p_rr_ready;
        (port_state != 2'h3) [*3] |-> !rr_send_req;
    endproperty
    a_rr_ready: assert property (p_rr_ready) else $error("ready pair outside ready");
    property p_rr_buf;
        (!rx_buf_free) [*3] |-> !rr_send_req;
    endproperty
    a_rr_buf: assert property (p_rr_buf) else $error("ready pair with no buffer");
    property p_ret;
        return_token_rx != 2'h0 |=> (return_fwd | return_refl) == $past(return_token_rx);
    endproperty
    a_ret: assert property (p_ret) else $error("return token not passed at once");
    property p_one_way;
        ((token_fwd & token_refl) | (return_fwd & return_refl)) == 2'h0;
    endproperty
    a_one_way: assert property (p_one_way) else $error("token both forwarded and reflected");
endmodule // link_pacing_fairness_ctrl_asserts
bind link_pacing_fairness_ctrl link_pacing_fairness_ctrl_asserts u_chk (
    .mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .port_state(port_state), .rx_buf_free(rx_buf_free),
    .tx_frame_permit(tx_frame_permit), .tx_control_permit(tx_control_permit),
    .rr_send_req(rr_send_req), .return_token_rx(return_token_rx), .token_fwd(token_fwd),
    .token_refl(token_refl), .return_fwd(return_fwd), .return_refl(return_refl)
);
`default_nettype wire

// >>> link_pacing_fairness_ctrl_tb.sv
// testbench for the pacing and fairness controller
`timescale 1ns/100ps
`default_nettype none
module link_pacing_fairness_ctrl_tb;
    // ****************************************
    // signals
    // ****************************************
    logic mclk, resetn, cyc, stb, we, rx_buf_free, clr;
    logic [7:0] adr, seen;
    logic [3:0] sel;
    logic [31:0] dat, rdat;
    logic [1:0] port_state, frames_waiting, cut;
    logic [14:0] pv;  // input pulses, bit 14 marks a sent ready char
    wire [31:0] dat_o;
    wire ack, fperm, cperm, rr_req, rx_valid, rx_rr;
    wire [1:0] t_fwd, t_refl, r_fwd, r_refl, operm;
    int miscompares = 0, compares = 0, cycles = 0;
    link_pacing_fairness_ctrl u_dut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .port_state(port_state), .rx_char_valid(rx_valid),
        .rx_char_is_rr(rx_rr), .rx_ctrl_field_paced(pv[0]), .rx_buf_free(rx_buf_free),
        .rx_buf_added(pv[1]), .rx_buf_removed(pv[2]), .tx_char_sent(pv[7]),
        .tx_char_is_rr(pv[14]), .tx_ctrl_field_paced(pv[3]), .tx_rr_pair_done(pv[4]),
        .tx_frame_permit(fperm), .tx_control_permit(cperm), .rr_send_req(rr_req),
        .xfer_open(pv[5]), .xfer_close(pv[6]), .token_rx(pv[9:8]),
        .return_token_rx(pv[11:10]), .app_frame_done(pv[13:12]),
        .frames_waiting(frames_waiting), .cut_through_pending(cut), .token_fwd(t_fwd),
        .token_refl(t_refl), .return_fwd(r_fwd), .return_refl(r_refl),
        .originate_permit(operm));
    rr_peer u_peer (.mclk(mclk), .char_valid(rx_valid), .char_is_rr(rx_rr));
    // token pulses gathered between clears
    always @(posedge mclk) begin
        seen <= clr ? 8'h00 : (seen | {r_refl, r_fwd, t_refl, t_fwd});
        cycles++;
        if (cycles == 20000) begin
            miscompares++;  // hang cut short
            wrap_up();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; waits for ack, no fixed latency assumed
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
        do @(posedge mclk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task pulse(input int i);
        @(posedge mclk);
        pv[i] <= 1'b1;
        @(posedge mclk);
        pv[i] <= 1'b0;
    endtask
    task clear_seen;
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
    endtask
    task t_bus;
        wb(1, 8'h00, 32'h00000002);
        wb(0, 8'h00, 32'h0);
        chk(rdat, 32'h00000002);
        wb(0, 8'h20, 32'h0);
        chk(rdat, 32'h00000000);  // unmapped reads zero
        wb(1, 8'h00, 32'h00000000);
    endtask
    task t_plain;
        rx_buf_free <= 1'b1;
        port_state <= 2'h1;
        wb(1, 8'h0C, 32'hFFFFFFFF);  // read-only, ignored
        wb(0, 8'h0C, 32'h0);
        chk(rdat & 32'h0001FFFF, 32'h00000101);
        chk(cperm, 1'b1);
        port_state <= 2'h3;
        repeat (4) @(posedge mclk);
        chk({fperm, rr_req}, 2'h1);
        rx_buf_free <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(rr_req, 1'b0);
        rx_buf_free <= 1'b1;
        u_peer.send_pair(1'b1);
        repeat (4) @(posedge mclk);
        chk(fperm, 1'b0);
        u_peer.send_pair(1'b0);
        repeat (4) @(posedge mclk);
        chk(fperm, 1'b1);
        pulse(4);
        repeat (4) @(posedge mclk);
        chk(rr_req, 1'b0);
        pulse(0);
        pulse(0);
        repeat (4) @(posedge mclk);
        chk(rr_req, 1'b1);
        // a ready char just sent blocks the next pair
        pv[14] <= 1'b1;
        pulse(7);
        repeat (2) @(posedge mclk);
        chk(rr_req, 1'b0);
        pv[14] <= 1'b0;
        pulse(7);
        repeat (2) @(posedge mclk);
        chk(rr_req, 1'b1);
        wb(0, 8'h0C, 32'h0);
        chk(rdat & 32'h0001FFFF, 32'h00000100);
        pulse(3);
        repeat (4) @(posedge mclk);
        chk(fperm, 1'b0);
    endtask
    task t_cap;
        wb(1, 8'h00, 32'h00000004);
        wb(1, 8'h08, 32'h00000204);
        port_state <= 2'h0;
        wb(1, 8'h00, 32'h00000004);
        port_state <= 2'h1;
        wb(0, 8'h0C, 32'h0);
        chk(rdat & 32'h0001FFFF, 32'h000001FF);
        wb(1, 8'h00, 32'h00000005);
        pulse(3);  // outstanding wraps to zero
        pulse(1);
        wb(0, 8'h0C, 32'h0);
        chk(rdat & 32'h0001FFFF, 32'h00000400);
        repeat (4) pulse(2);
        wb(1, 8'h00, 32'h00000004);
        port_state <= 2'h3;
        wb(0, 8'h0C, 32'h0);
        chk(rdat & 32'h0001FFFF, 32'h0001FE00);
        repeat (3) @(posedge mclk);
        chk(rr_req, 1'b0);
    endtask
    task t_fair;
        wb(1, 8'h04, 32'h00000302);
        pulse(5);
        frames_waiting <= 2'h1;
        wb(0, 8'h14, 32'h0);
        chk(rdat & 32'h000000FF, 32'h00000001);
        chk(operm, 2'h3);
        cut <= 2'h2;
        repeat (2) @(posedge mclk);
        chk(operm, 2'h1);
        cut <= 2'h3;
        repeat (2) @(posedge mclk);
        chk(operm, 2'h0);
        clear_seen();
        pulse(8);
        pulse(12);
        wb(0, 8'h10, 32'h0);
        chk(rdat, 32'h00000001);
        chk(seen, 8'h00);
        chk(operm, 2'h1);
        pulse(12);
        repeat (3) @(posedge mclk);
        chk(seen, 8'h01);
        pulse(13);
        wb(0, 8'h10, 32'h0);
        chk(rdat, 32'h00010000);
        wb(1, 8'h00, 32'h00000002);
        clear_seen();
        pulse(9);
        repeat (4) @(posedge mclk);
        chk(seen, 8'h08);
        clear_seen();
        pulse(11);
        repeat (2) @(posedge mclk);
        chk(seen, 8'h80);
        wb(1, 8'h00, 32'h00000000);
        clear_seen();
        pulse(10);
        repeat (2) @(posedge mclk);
        chk(seen, 8'h10);
    endtask
    task wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************
    // clock and main sequence
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        {resetn, cyc, stb, we, adr, sel, dat, clr, seen} = '0;
        {pv, port_state, frames_waiting, rx_buf_free, cut} = '0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        t_bus();
        t_plain();
        t_cap();
        t_fair();
        wrap_up();
    end
endmodule // link_pacing_fairness_ctrl_tb
`default_nettype wire

// >>> rr_peer.sv
// remote port model sending receiver-ready characters
`timescale 1ns/100ps
`default_nettype none
module rr_peer (
    // clock and character stream toward the block
    input wire logic mclk,
    output logic char_valid,
    output logic char_is_rr
);
    // idle line: no character
    initial begin
        char_valid = 1'b0;
        char_is_rr = 1'b0;
    end
    // two ready chars, optionally split by a filler
    task send_pair(input logic split);
        begin
            @(posedge mclk);
            char_valid <= 1'b1;
            char_is_rr <= 1'b1;
            if (split) begin
                @(posedge mclk);
                char_is_rr <= 1'b0;  // filler breaks the pair
            end
            @(posedge mclk);
            char_is_rr <= 1'b1;
            @(posedge mclk);
            char_is_rr <= 1'b0;  // trailing filler closes any lone half
            @(posedge mclk);
            char_valid <= 1'b0;
        end
    endtask
endmodule // rr_peer
`default_nettype wire
